// File: common/fpd_pkg.sv
// Package for the fan drive block: register offsets, reset values,
// field positions, time constants and shared decode functions.
// Assumes a register port addressed by the documented 8-bit offsets.
package fpd_pkg;

	// Register offsets
	localparam logic [7:0] OFS_FAN_PULSE_INPUT_LO1 = 8'h28;
	localparam logic [7:0] OFS_DUTY1 = 8'h30;
	localparam logic [7:0] OFS_DUTY2 = 8'h31;
	localparam logic [7:0] OFS_DUTY3 = 8'h32;
	localparam logic [7:0] OFS_DMIN1 = 8'h36;
	localparam logic [7:0] OFS_CFG1 = 8'h40;
	localparam logic [7:0] OFS_PCFG1 = 8'h5c;
	localparam logic [7:0] OFS_PCFG2 = 8'h5d;
	localparam logic [7:0] OFS_PCFG3 = 8'h5e;
	localparam logic [7:0] OFS_FREQ1 = 8'h5f;
	localparam logic [7:0] OFS_FREQ2 = 8'h60;
	localparam logic [7:0] OFS_FREQ3 = 8'h61;
	localparam logic [7:0] OFS_BTEST = 8'h6f;
	localparam logic [7:0] OFS_CFG2 = 8'h73;
	localparam logic [7:0] OFS_PPR = 8'h7b;
	localparam logic [7:0] OFS_CFG4 = 8'h7d;

	// Reset values
	localparam logic [7:0] RST_DUTY = 8'h00;
	localparam logic [7:0] RST_PCFG = 8'h02;
	localparam logic [7:0] RST_DRIVE_RATE_SEL = 8'h04;
	localparam logic [7:0] RST_PPR = 8'h55;
	localparam logic [7:0] RST_ZERO = 8'h00;

	// Field positions
	localparam int SPIN_LSB = 0;
	localparam int INV_BIT = 4;
	localparam int OUTPUT_BEHAVIOUR_LSB = 5;
	localparam logic [2:0] OUTPUT_BEHAVIOUR_MANUAL = 3'h7;
	localparam int FIXED_SPINUP_SELECT_BIT = 5;
	localparam int CORE_LO_BIT = 1;
	localparam int BTEST_BIT = 0;
	localparam int SENSE_THRESHOLD_SEL_LSB = 2;
	localparam logic [7:0] DUTY_FULL = 8'hff;

	// Times, rates and counts in their own units
	localparam int FAILSAFE_MS = 4600;
	localparam int HF_RATE_HZ = 22500;
	localparam int FAN_PULSE_INPUT_OSC_HZ = 90000;
	localparam int MS_PER_S = 1000;
	localparam int DUTY_STEPS = 256;
	localparam int SPIN_PULSES = 2;

	// Startup timeout in ms per code; code 0 means none
	function automatic logic [12:0] spin_ms(input logic [2:0] code);
		case (code)
			3'h1: spin_ms = 13'd100;
			3'h2: spin_ms = 13'd250;
			3'h3: spin_ms = 13'd400;
			3'h4: spin_ms = 13'd667;
			3'h5: spin_ms = 13'd1000;
			3'h6: spin_ms = 13'd2000;
			3'h7: spin_ms = 13'd4000;
			default: spin_ms = 13'd0;
		endcase
	endfunction

	// Low-frequency drive rate in tenths of a hertz
	function automatic int rate_tenths(input logic [2:0] code);
		case (code)
			3'h0: rate_tenths = 110;
			3'h1: rate_tenths = 147;
			3'h2: rate_tenths = 221;
			3'h3: rate_tenths = 294;
			3'h4: rate_tenths = 353;
			3'h5: rate_tenths = 441;
			3'h6: rate_tenths = 588;
			default: rate_tenths = 882;
		endcase
	endfunction

	// Clock cycles per duty step, never below one
	function automatic logic [31:0] step_cycles(input longint clk_hz, input logic hf,
		input logic [2:0] code);
		longint c;
		c = hf ? clk_hz / (DUTY_STEPS * HF_RATE_HZ)
			: (clk_hz * 10) / (DUTY_STEPS * rate_tenths(code));
		if (c < 1) c = 1;
		step_cycles = c[31:0];
	endfunction

endpackage

// File: verilog/fpd_pwm_chan.sv
// One drive output: duty step counter at the selected rate, polarity.
// Assumes duty and selections are steady flops of the register block.
`timescale 1ns/1ps
`default_nettype none
module fpd_pwm_chan #(
	parameter int CLK_HZ = 200_000_000
) (
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire logic [7:0] duty_i,
	input wire logic hf_i,
	input wire logic [2:0] rate_sel_i,
	input wire logic invert_i,
	output logic pwm_o
);
	import fpd_pkg::*;

	typedef struct packed {
		logic [31:0] div;
		logic [7:0] phase;
		logic out;
	} fpd_chan_t;

	fpd_chan_t s_q, s_d;
	logic [31:0] step;

	// Next state: step divider, phase, compare and polarity
	always_comb begin
		step = step_cycles(longint'(CLK_HZ), hf_i, rate_sel_i); // R9 R10
		s_d = s_q;
		if (s_q.div == 32'h0) begin
			s_d.div = step - 32'h1;
			s_d.phase = s_q.phase + 8'h1;
		end else begin
			s_d.div = s_q.div - 32'h1;
		end
		s_d.out = ((duty_i == DUTY_FULL) || (s_q.phase < duty_i)) ^ invert_i; // R8 R12
	end

	// State register
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign pwm_o = s_q.out;
endmodule
`default_nettype wire

// File: verilog/fpd_fan_ctrl.sv
// Fan drive block: registers, spin-up, period measure, low-core hold,
// power-on fail-safe and three drive outputs.
// Assumes a synchronous register port and comparator levels from outside.
`timescale 1ns/1ps
`default_nettype none
// Operation
// [R1] Four two-bit pulses-per-revolution fields, code+1 pulses, default two.
// [R2] Config two bits 0-3 turn fan_pulse_input inputs into analog sense, low-frequency only.
// [R3] Config four bits 3:2 pick one of four analog sense thresholds.
// [R4] On start drive full duty until two fan_pulse_input pulses, then running duty.
// [R5] Flag a fault if two pulses do not arrive within the timeout.
// [R6] Output config bits 2:0 pick startup timeout, none to 4 s, 250 ms default.
// [R7] Config one bit 5 gives fixed-time full-duty spin-up instead of pulses.
// [R8] Output config bit 4 inverts the output; full duty then is low.
// [R9] Low-frequency rate from a three-bit field, 11.0 to 88.2 Hz, 35.3 default.
// [R10] High-frequency mode uses one fixed rate and ignores the rate field.
// [R11] Behaviour field 111 means manual: duty follows the duty register.
// [R12] Eight-bit duty registers span 0 to 100 percent, reset zero.
// [R13] Reading a duty register returns the duty really driven.
// [R14] Automatic mode takes duty from the temperature loop without host help.
// [R15] With hold enabled, low core voltage sets a status bit and alert.
// [R16] During low core voltage hold thermal monitor, min-temp adjust, shutdown.
// [R17] Core voltage back above limit resumes all suspended functions.
// [R18] Board test register bit 0 enables the chain test mode.
// [R19] Core rail off at power-up: defaults once addressed by the host.
// [R20] Core rail up: fail-safe countdown, full speed if not addressed in time.
// [R21] Addressed after full speed: fans stop, defaults load, normal operation.
// [R22] Addressed before countdown ends: normal operation, no forced full speed.
// [R23] Fan period counted at 90 kHz into 16 bits over the set pulses.
// [R24] Fail-safe full drive keeps polarity; fan_pulse_input pulses count on rising edge.
module fpd_fan_ctrl #(
	parameter int CLK_HZ = 200_000_000,
	parameter int FAILSAFE_TIME_MS = fpd_pkg::FAILSAFE_MS
) (
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	input wire logic smbus_addressed_i,
	input wire logic [3:0] fan_pulse_input_i,
	input wire logic hf_mode_i,
	input wire logic [2:0][7:0] auto_duty_i,
	input wire logic processor_core_voltage_up_i,
	input wire logic processor_core_voltage_low_i,
	input wire logic alert_en_i,
	output logic [2:0] pwm_o,
	output logic [2:0] spin_fail_o,
	output logic [3:0] analog_fan_sense_o,
	output logic [1:0] sense_threshold_sel_o,
	output logic core_low_status_o,
	output logic alert_o,
	output logic thermal_alarm_pin_hold_o,
	output logic min_temp_point_hold_o,
	output logic shutdown_block_o,
	output logic board_test_en_o,
	output logic failsafe_full_o
);
	import fpd_pkg::*;

	localparam int MS_CYC = (CLK_HZ / MS_PER_S < 1) ? 1 : CLK_HZ / MS_PER_S;
	localparam int OSC_CYC = (CLK_HZ / FAN_PULSE_INPUT_OSC_HZ < 1) ? 1 : CLK_HZ / FAN_PULSE_INPUT_OSC_HZ;

	typedef enum logic [1:0] {SP_IDLE, SP_SPIN, SP_RUN} fpd_spin_t;
	typedef enum logic [1:0] {FS_POLL, FS_COUNT, FS_FULL, FS_NORMAL} fpd_fs_t;

	typedef struct packed {
		logic [2:0][7:0] duty;
		logic [7:0] dmin1;
		logic [7:0] cfg1;
		logic [2:0][7:0] pcfg;
		logic [2:0][7:0] drive_rate_sel;
		logic [7:0] btest;
		logic [7:0] cfg2;
		logic [7:0] cfg4;
		logic [7:0] ppr;
		logic [7:0] rdata;
		logic [3:0] fan_pulse_input_prev;
		logic [31:0] ms_div;
		logic [31:0] osc_div;
		logic [2:0][1:0] spin_st;
		logic [2:0][12:0] spin_ms_cnt;
		logic [2:0][1:0] spin_pulses;
		logic [2:0] spin_fail;
		logic [2:0] was_on;
		logic [3:0] meas_act;
		logic [3:0][2:0] meas_pc;
		logic [3:0][15:0] meas_cnt;
		logic [3:0][15:0] period;
		logic [1:0] fs_st;
		logic [12:0] fs_ms;
	} fpd_state_t;

	// Fan_pulse_input history resets to the pulled-up idle level, so reset gives no false edge
	localparam fpd_state_t RST_S = '{
		duty: {3{RST_DUTY}}, dmin1: RST_ZERO, cfg1: RST_ZERO, pcfg: {3{RST_PCFG}},
		drive_rate_sel: {3{RST_DRIVE_RATE_SEL}}, btest: RST_ZERO, cfg2: RST_ZERO, cfg4: RST_ZERO,
		ppr: RST_PPR, rdata: RST_ZERO, fan_pulse_input_prev: 4'hf, ms_div: 32'h0, osc_div: 32'h0,
		spin_st: {3{SP_IDLE}}, spin_ms_cnt: '0, spin_pulses: '0, spin_fail: 3'h0,
		was_on: 3'h0, meas_act: 4'h0, meas_pc: '0, meas_cnt: '0, period: '0,
		fs_st: FS_POLL, fs_ms: 13'h0};

	fpd_state_t s_q, s_d;
	logic ms_tick, osc_tick, core_hold, full_all;
	logic [3:0] fan_pulse_input_rise;
	logic [2:0][7:0] target, driven;
	logic [2:0] invert;

	// Shared time bases: one millisecond tick and the 90 kHz measuring tick
	assign ms_tick = (s_q.ms_div == 32'h0);
	assign osc_tick = (s_q.osc_div == 32'h0);
	// Rising edges only; inputs set in config two bits 0-3 give no pulses in high-frequency mode
	assign fan_pulse_input_rise = fan_pulse_input_i & ~s_q.fan_pulse_input_prev & ~(s_q.cfg2[3:0] & {4{hf_mode_i}}); // R2 R24
	assign core_hold = s_q.dmin1[CORE_LO_BIT] & processor_core_voltage_low_i; // R15 R17
	assign full_all = (s_q.fs_st == FS_FULL); // R20

	// Duty selection per output: manual, automatic, spin-up and fail-safe
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			if (s_q.pcfg[i][OUTPUT_BEHAVIOUR_LSB +: 3] == OUTPUT_BEHAVIOUR_MANUAL) begin
				target[i] = s_q.duty[i]; // R11
			end else begin
				target[i] = auto_duty_i[i]; // R14
			end
			if (full_all || s_q.spin_st[i] == SP_SPIN) begin
				driven[i] = DUTY_FULL; // R4 R24
			end else begin
				driven[i] = target[i];
			end
			invert[i] = s_q.pcfg[i][INV_BIT];
		end
	end

	// Read decode shared by the read data path
	function automatic logic [7:0] rd_mux(input fpd_state_t s, input logic [7:0] a,
		input logic [2:0][7:0] drv);
		rd_mux = 8'h00;
		case (a)
			OFS_DUTY1: rd_mux = drv[0]; // R13
			OFS_DUTY2: rd_mux = drv[1];
			OFS_DUTY3: rd_mux = drv[2];
			OFS_DMIN1: rd_mux = s.dmin1;
			OFS_CFG1: rd_mux = s.cfg1;
			OFS_PCFG1: rd_mux = s.pcfg[0];
			OFS_PCFG2: rd_mux = s.pcfg[1];
			OFS_PCFG3: rd_mux = s.pcfg[2];
			OFS_FREQ1: rd_mux = s.drive_rate_sel[0];
			OFS_FREQ2: rd_mux = s.drive_rate_sel[1];
			OFS_FREQ3: rd_mux = s.drive_rate_sel[2];
			OFS_BTEST: rd_mux = s.btest;
			OFS_CFG2: rd_mux = s.cfg2;
			OFS_CFG4: rd_mux = s.cfg4;
			OFS_PPR: rd_mux = s.ppr;
			default: begin
				if (a >= OFS_FAN_PULSE_INPUT_LO1 && a < OFS_DUTY1) begin
					rd_mux = a[0] ? s.period[a[2:1]][15:8] : s.period[a[2:1]][7:0];
				end
			end
		endcase
	endfunction

	// Next state
	always_comb begin
		s_d = s_q;
		s_d.fan_pulse_input_prev = fan_pulse_input_i;
		s_d.ms_div = ms_tick ? 32'(MS_CYC - 1) : s_q.ms_div - 32'h1;
		s_d.osc_div = osc_tick ? 32'(OSC_CYC - 1) : s_q.osc_div - 32'h1;

		// Register writes
		if (reg_wr_i) begin
			case (reg_addr_i)
				OFS_DUTY1: s_d.duty[0] = reg_wdata_i; // R12
				OFS_DUTY2: s_d.duty[1] = reg_wdata_i;
				OFS_DUTY3: s_d.duty[2] = reg_wdata_i;
				OFS_DMIN1: s_d.dmin1 = reg_wdata_i;
				OFS_CFG1: s_d.cfg1 = reg_wdata_i;
				OFS_PCFG1: s_d.pcfg[0] = reg_wdata_i;
				OFS_PCFG2: s_d.pcfg[1] = reg_wdata_i;
				OFS_PCFG3: s_d.pcfg[2] = reg_wdata_i;
				OFS_FREQ1: s_d.drive_rate_sel[0] = reg_wdata_i;
				OFS_FREQ2: s_d.drive_rate_sel[1] = reg_wdata_i;
				OFS_FREQ3: s_d.drive_rate_sel[2] = reg_wdata_i;
				OFS_BTEST: s_d.btest = reg_wdata_i;
				OFS_CFG2: s_d.cfg2 = reg_wdata_i;
				OFS_CFG4: s_d.cfg4 = reg_wdata_i;
				OFS_PPR: s_d.ppr = reg_wdata_i; // R1
				default: ;
			endcase
		end
		if (reg_rd_i) begin
			s_d.rdata = rd_mux(s_q, reg_addr_i, driven);
		end

		// Spin-up per output, started when the wanted duty leaves zero
		for (int i = 0; i < 3; i++) begin
			s_d.was_on[i] = (target[i] != 8'h00);
			case (s_q.spin_st[i])
				SP_IDLE: begin
					if (target[i] != 8'h00) begin
						s_d.spin_st[i] = SP_SPIN; // R4
						s_d.spin_ms_cnt[i] = spin_ms(s_q.pcfg[i][SPIN_LSB +: 3]); // R6
						s_d.spin_pulses[i] = 2'h0;
						s_d.spin_fail[i] = 1'b0;
					end
				end
				SP_SPIN: begin
					if (fan_pulse_input_rise[i] && s_q.spin_pulses[i] != 2'h3) begin
						s_d.spin_pulses[i] = s_q.spin_pulses[i] + 2'h1;
					end
					if (ms_tick && s_q.spin_ms_cnt[i] != 13'h0) begin
						s_d.spin_ms_cnt[i] = s_q.spin_ms_cnt[i] - 13'h1;
					end
					if (s_q.cfg1[FIXED_SPINUP_SELECT_BIT]) begin
						if (s_q.spin_ms_cnt[i] == 13'h0) begin
							s_d.spin_st[i] = SP_RUN; // R7
						end
					end else if (s_q.spin_pulses[i] >= 2'(SPIN_PULSES)) begin
						s_d.spin_st[i] = SP_RUN; // R4
					end else if (ms_tick && s_q.spin_ms_cnt[i] == 13'h1) begin
						s_d.spin_fail[i] = 1'b1; // R5
						s_d.spin_st[i] = SP_RUN;
					end
				end
				SP_RUN: begin
					if (target[i] == 8'h00) begin
						s_d.spin_st[i] = SP_IDLE;
					end
				end
				default: s_d.spin_st[i] = SP_IDLE;
			endcase
		end

		// Fan period: count 90 kHz ticks from one rising edge over N pulses
		for (int f = 0; f < 4; f++) begin
			if (s_q.meas_act[f] && osc_tick && s_q.meas_cnt[f] != 16'hffff) begin
				s_d.meas_cnt[f] = s_q.meas_cnt[f] + 16'h1; // R23
			end
			if (s_q.meas_act[f] && s_q.meas_cnt[f] == 16'hffff) begin
				s_d.period[f] = 16'hffff;
				s_d.meas_act[f] = 1'b0;
			end else if (fan_pulse_input_rise[f]) begin
				if (!s_q.meas_act[f]) begin
					s_d.meas_act[f] = 1'b1;
					s_d.meas_pc[f] = 3'h0;
					s_d.meas_cnt[f] = 16'h0;
				end else if (s_q.meas_pc[f] == {1'b0, s_q.ppr[2*f +: 2]}) begin
					s_d.period[f] = s_q.meas_cnt[f]; // R1 R23
					s_d.meas_act[f] = 1'b0;
				end else begin
					s_d.meas_pc[f] = s_q.meas_pc[f] + 3'h1;
				end
			end
		end

		// Power-on fail-safe sequence
		case (s_q.fs_st)
			FS_POLL: begin
				if (smbus_addressed_i) begin
					s_d.fs_st = FS_NORMAL; // R19
				end else if (processor_core_voltage_up_i) begin
					s_d.fs_st = FS_COUNT; // R20
					s_d.fs_ms = 13'(FAILSAFE_TIME_MS);
				end
			end
			FS_COUNT: begin
				if (smbus_addressed_i) begin
					s_d.fs_st = FS_NORMAL; // R22
				end else if (s_q.fs_ms == 13'h0) begin
					s_d.fs_st = FS_FULL; // R20
				end else if (ms_tick) begin
					s_d.fs_ms = s_q.fs_ms - 13'h1;
				end
			end
			FS_FULL: begin
				if (smbus_addressed_i) begin
					s_d = RST_S; // R21
					s_d.fs_st = FS_NORMAL;
					// Read data is not a setting: it holds, or answers a read in this cycle
					s_d.rdata = reg_rd_i ? rd_mux(s_q, reg_addr_i, driven) : s_q.rdata;
				end
			end
			FS_NORMAL: ;
			default: s_d.fs_st = FS_POLL;
		endcase
	end

	// State register
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s_q <= RST_S;
		end else begin
			s_q <= s_d;
		end
	end

	// Three drive outputs
	for (genvar g = 0; g < 3; g++) begin : g_out
		fpd_pwm_chan #(.CLK_HZ(CLK_HZ)) u_chan (
			.core_clk_i(core_clk_i),
			.rstn_i(rstn_i),
			.duty_i(driven[g]),
			.hf_i(hf_mode_i), // R10
			.rate_sel_i(s_q.drive_rate_sel[g][2:0]), // R9
			.invert_i(invert[g]), // R8 R24
			.pwm_o(pwm_o[g])
		);
	end

	// Status and mode outputs
	assign reg_rdata_o = s_q.rdata;
	assign spin_fail_o = s_q.spin_fail;
	assign analog_fan_sense_o = s_q.cfg2[3:0] & ~{4{hf_mode_i}}; // R2
	assign sense_threshold_sel_o = s_q.cfg4[SENSE_THRESHOLD_SEL_LSB +: 2]; // R3
	assign core_low_status_o = core_hold; // R15
	assign alert_o = core_hold & alert_en_i; // R15
	assign thermal_alarm_pin_hold_o = core_hold; // R16
	assign min_temp_point_hold_o = core_hold; // R16
	assign shutdown_block_o = core_hold; // R16
	assign board_test_en_o = s_q.btest[BTEST_BIT]; // R18
	assign failsafe_full_o = full_all;
endmodule
`default_nettype wire

// File: test/fpd_fan_assertions.sv
// Checker for the fan drive block, watching top-level ports only.
// Assumes a bind onto fpd_fan_ctrl with connections by name.
`timescale 1ns/1ps
`default_nettype none
module fpd_fan_assertions (
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic smbus_addressed_i,
	input wire logic hf_mode_i,
	input wire logic alert_en_i,
	input wire logic [2:0] pwm_o,
	input wire logic [3:0] analog_fan_sense_o,
	input wire logic core_low_status_o,
	input wire logic alert_o,
	input wire logic thermal_alarm_pin_hold_o,
	input wire logic min_temp_point_hold_o,
	input wire logic shutdown_block_o,
	input wire logic failsafe_full_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rstn_i);
	// Full drive settled, and a host access arriving during it
	sequence s_full_held;
		failsafe_full_o [*4];
	endsequence
	sequence s_addr_in_full;
		failsafe_full_o && smbus_addressed_i;
	endsequence
	// Output relations
	a_alert_gate: assert property (alert_o == (core_low_status_o && alert_en_i))
		else $error("alert does not follow low core status and enable");
	a_hold_follow: assert property ((thermal_alarm_pin_hold_o == core_low_status_o)
		&& (min_temp_point_hold_o == core_low_status_o))
		else $error("monitor holds do not follow low core status");
	a_shutdown_blk: assert property (shutdown_block_o == core_low_status_o)
		else $error("shutdown block does not follow low core status");
	a_full_steady: assert property (s_full_held |-> $stable(pwm_o))
		else $error("outputs toggle during full drive");
	a_leave_full: assert property (s_addr_in_full |-> ##[1:3] !failsafe_full_o)
		else $error("full drive kept after host access");
	a_full_duty_rd: assert property (reg_rd_i && reg_addr_i == 8'h30 && failsafe_full_o
		|=> reg_rdata_o == 8'hff)
		else $error("duty read during full drive is not ff");
	a_rdata_hold: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
		else $error("read data changed without a read");
	a_unmapped_rd: assert property (reg_rd_i && reg_addr_i == 8'hff |=> reg_rdata_o == 8'h00)
		else $error("unmapped read not zero");
	a_hf_no_sense: assert property (hf_mode_i && $past(hf_mode_i)
		|-> analog_fan_sense_o == 4'h0)
		else $error("analog sense active in high-frequency mode");
endmodule
`default_nettype wire

// File: test/fpd_fan_model.sv
// Model of four fans with open-drain fan_pulse_input outputs and pull-ups.
// Assumes the bench picks which fans turn and a prompt or slow rate.
`timescale 1ns/1ps
`default_nettype none
module fpd_fan_model (
	input wire logic core_clk_i,
	input wire logic [3:0] run_i,
	input wire logic slow_i,
	output logic [3:0] fan_pulse_input_o
);
	logic [8:0] cnt_q = 9'h0;
	// Pulse phase, period 40 cycles prompt or 400 slow
	always_ff @(posedge core_clk_i) begin
		cnt_q <= (cnt_q >= (slow_i ? 9'd399 : 9'd39)) ? 9'h0 : cnt_q + 9'h1;
	end
	// A stopped fan releases the line and the pull-up holds it high
	always_comb begin
		for (int f = 0; f < 4; f++) begin
			fan_pulse_input_o[f] = run_i[f] ? (cnt_q < (slow_i ? 9'd200 : 9'd20)) : 1'b1;
		end
	end
endmodule
`default_nettype wire

// File: test/test_fpd_fan_ctrl.sv
// Testbench for the fan drive block with fan model and checker.
// Assumes short counts: 1 ms is 200 cycles, fail-safe 5 ms.
`timescale 1ns/1ps
`default_nettype none
module test_fpd_fan_ctrl;
	logic core_clk_i = 1'b0, rstn_i = 1'b0, wr = 1'b0, rd = 1'b0, addressed = 1'b0;
	logic hf = 1'b0, core_up = 1'b0, core_low = 1'b0, alert_en = 1'b0, slow = 1'b0;
	logic [7:0] addr = 8'h0, wdata = 8'h0, rdata;
	logic [3:0] run = 4'h0, fan_pulse_input, sense;
	logic [2:0][7:0] auto_duty = '0;
	logic [2:0] pwm, spin_fail;
	logic [1:0] thr;
	logic low_st, alert, hold_a, hold_b, shut_blk, btest, full;
	int n_mismatch = 0, n_tests = 0;
	fpd_fan_model u_fpd_fan_model (.core_clk_i(core_clk_i), .run_i(run), .slow_i(slow),
		.fan_pulse_input_o(fan_pulse_input));
	fpd_fan_ctrl #(.CLK_HZ(200000), .FAILSAFE_TIME_MS(5)) u_fpd_fan_ctrl (
		.core_clk_i(core_clk_i), .rstn_i(rstn_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
		.reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .smbus_addressed_i(addressed),
		.fan_pulse_input_i(fan_pulse_input), .hf_mode_i(hf), .auto_duty_i(auto_duty),
		.processor_core_voltage_up_i(core_up), .processor_core_voltage_low_i(core_low),
		.alert_en_i(alert_en), .pwm_o(pwm), .spin_fail_o(spin_fail),
		.analog_fan_sense_o(sense), .sense_threshold_sel_o(thr), .core_low_status_o(low_st),
		.alert_o(alert), .thermal_alarm_pin_hold_o(hold_a), .min_temp_point_hold_o(hold_b),
		.shutdown_block_o(shut_blk), .board_test_en_o(btest), .failsafe_full_o(full));
	// Clock at 200 MHz
	always #2.5 core_clk_i = ~core_clk_i;
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		addr = a;
		wdata = d;
		wr = 1'b1;
		cyc(1);
		wr = 1'b0;
		cyc(1);
	endtask
	task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
		addr = a;
		rd = 1'b1;
		cyc(1);
		rd = 1'b0;
		chk(rdata, e);
		cyc(1);
	endtask
	task automatic do_reset();
		rstn_i = 1'b0;
		cyc(16);
		rstn_i = 1'b1;
	endtask
	task automatic host_access();
		addressed = 1'b1;
		cyc(1);
		addressed = 1'b0;
		cyc(3);
	endtask
	// Reset values of every writable register, plus an unmapped place
	task automatic t_reset_vals();
		logic [15:0] tbl [16] = '{16'h3000, 16'h3100, 16'h3200, 16'h5c02, 16'h5d02, 16'h5e02,
			16'h5f04, 16'h6004, 16'h6104, 16'h7b55, 16'h7300, 16'h7d00, 16'h6f00, 16'h4000,
			16'h3600, 16'hff00};
		foreach (tbl[i]) rd_reg(tbl[i][15:8], tbl[i][7:0]);
	endtask
	// Countdown lapses, then a host access ends full drive
	task automatic t_failsafe();
		core_up = 1'b1;
		cyc(1100);
		chk(8'(full), 8'h1);
		chk(8'(pwm), 8'h7);
		rd_reg(8'h30, 8'hff);
		host_access();
		chk(8'(full), 8'h0);
		rd_reg(8'h30, 8'h00);
		chk(8'(pwm), 8'h0);
	endtask
	// Host access inside the countdown prevents full drive
	task automatic t_early();
		do_reset();
		cyc(100);
		host_access();
		cyc(1100);
		chk(8'(full), 8'h0);
	endtask
	// Manual duty with spin-up on a slow fan, then polarity
	task automatic t_spinup();
		slow = 1'b1;
		wr_reg(8'h5c, 8'he2);
		wr_reg(8'h30, 8'h80);
		rd_reg(8'h30, 8'hff);
		run[0] = 1'b1;
		cyc(100);
		rd_reg(8'h30, 8'hff);
		cyc(900);
		rd_reg(8'h30, 8'h80);
		slow = 1'b0;
		wr_reg(8'h30, 8'hff);
		cyc(4);
		chk(8'(pwm[0]), 8'h1);
		wr_reg(8'h5c, 8'hf2);
		cyc(4);
		chk(8'(pwm[0]), 8'h0);
	endtask
	// Fixed rate in high-frequency mode: half duty gives half high time
	task automatic t_hf();
		logic [9:0] hi;
		hi = '0;
		wr_reg(8'h5c, 8'he2);
		wr_reg(8'h30, 8'h80);
		hf = 1'b1;
		cyc(600);
		repeat (512) begin
			hi = hi + 10'(pwm[0]);
			cyc(1);
		end
		chk(hi[8:1], 8'h80);
		hf = 1'b0;
	endtask
	// Stopped fan times out after 100 ms
	task automatic t_timeout();
		wr_reg(8'h5d, 8'he1);
		wr_reg(8'h31, 8'h40);
		cyc(19000);
		chk(8'(spin_fail[1]), 8'h0);
		cyc(1400);
		chk(8'(spin_fail[1]), 8'h1);
	endtask
	// Fixed-time spin-up ignores early pulses
	task automatic t_fixed();
		wr_reg(8'h40, 8'h20);
		wr_reg(8'h5e, 8'he1);
		run[2] = 1'b1;
		wr_reg(8'h32, 8'h10);
		cyc(200);
		rd_reg(8'h32, 8'hff);
		cyc(20400);
		rd_reg(8'h32, 8'h10);
		chk(8'(spin_fail[2]), 8'h0);
	endtask
	// Analog sense, thresholds, board test, pulses per revolution
	task automatic t_regs();
		wr_reg(8'h73, 8'h0f);
		chk(8'(sense), 8'h0f);
		hf = 1'b1;
		cyc(2);
		chk(8'(sense), 8'h00);
		hf = 1'b0;
		for (int c = 0; c < 4; c++) begin
			wr_reg(8'h7d, 8'(c << 2));
			chk(8'(thr), 8'(c));
		end
		wr_reg(8'h6f, 8'h01);
		chk(8'(btest), 8'h1);
		wr_reg(8'h7b, 8'h1b);
		rd_reg(8'h7b, 8'h1b);
	endtask
	// Low core voltage sets status and alert, recovery clears them
	task automatic t_corelow();
		alert_en = 1'b1;
		wr_reg(8'h36, 8'h02);
		core_low = 1'b1;
		cyc(2);
		chk(8'(alert), 8'h1);
		chk(8'(shut_blk), 8'h1);
		chk(8'(low_st), 8'h1);
		chk(8'({hold_a, hold_b}), 8'h3);
		core_low = 1'b0;
		cyc(2);
		chk(8'(low_st), 8'h0);
		chk(8'(alert), 8'h0);
	endtask
	// Running output handed to the automatic loop: reads follow the loop's duty
	task automatic t_auto();
		auto_duty[0] = 8'h5a;
		wr_reg(8'h5c, 8'h02);
		rd_reg(8'h30, 8'h5a);
		auto_duty[0] = 8'h00;
		cyc(2);
		rd_reg(8'h30, 8'h00);
	endtask
	task automatic results();
		$display("Mismatches %0d, comparisons %0d", n_mismatch, n_tests);
		if (n_mismatch == 0 && n_tests > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// Main sequence
	initial begin
		#1;
		do_reset();
		t_reset_vals();
		t_failsafe();
		t_early();
		t_spinup();
		t_hf();
		t_timeout();
		t_fixed();
		t_regs();
		t_corelow();
		t_auto();
		results();
	end
	// Watchdog well beyond the expected run
	initial begin
		#400000;
		n_mismatch++;
		results();
	end
endmodule
bind fpd_fan_ctrl fpd_fan_assertions u_fpd_fan_assertions (.core_clk_i(core_clk_i),
	.rstn_i(rstn_i), .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
	.smbus_addressed_i(smbus_addressed_i), .hf_mode_i(hf_mode_i), .alert_en_i(alert_en_i),
	.pwm_o(pwm_o), .analog_fan_sense_o(analog_fan_sense_o), .alert_o(alert_o),
	.core_low_status_o(core_low_status_o), .thermal_alarm_pin_hold_o(thermal_alarm_pin_hold_o),
	.min_temp_point_hold_o(min_temp_point_hold_o), .shutdown_block_o(shutdown_block_o),
	.failsafe_full_o(failsafe_full_o));
`default_nettype wire
